// ==== shared/dod_pkg.sv ====
// Package for the opcode decoder: patterns, field positions, types
// Assumes a 16-bit instruction word and one core clock
package dod_pkg;

  // ----------------------------------------------------------------
  // Opcode patterns
  // ----------------------------------------------------------------
  localparam logic [15:0] ABS_PAT = 16'hce1b;
  localparam logic [15:0] ROL_PAT = 16'hce34;
  localparam logic [15:0] ROR_PAT = 16'hce35;
  localparam logic [15:0] SFL_PAT = 16'hce18;
  localparam logic [15:0] SFR_PAT = 16'hce19;
  localparam logic [15:0] ADD_PRODUCT_OP_PAT = 16'hce15;
  localparam logic [15:0] PAC_PAT = 16'hce14;
  localparam logic [15:0] SUB_PRODUCT_OP_PAT = 16'hce16;
  localparam logic [3:0] ADD_NIB = 4'h0;
  localparam logic [3:0] LONG_NIB = 4'hd;
  localparam logic [3:0] LOADSH_NIB = 4'h2;
  localparam logic [7:0] LK_ADD = 8'h02;
  localparam logic [7:0] LK_SUB = 8'h03;
  localparam logic [7:0] LK_LOAD = 8'h01;
  localparam logic [7:0] LK_AND = 8'h04;
  localparam logic [7:0] LK_OR = 8'h05;
  localparam logic [7:0] LK_XOR = 8'h06;
  localparam logic [7:0] ADD_SHORT_CONST_OP_BYTE = 8'hcc;
  localparam logic [7:0] SUB_SHORT_CONST_OP_BYTE = 8'hcd;
  localparam logic [7:0] LOAD_ACC_SHORT_CONST_OP_BYTE = 8'hca;
  localparam logic [7:0] ADD_INDEX_SHORT_CONST_OP_BYTE = 8'h7e;
  localparam logic [7:0] MPY_BYTE = 8'h38;
  localparam logic [7:0] MAC_BYTE = 8'h5d;
  localparam logic [7:0] MULT_ACCUMULATE_MOVE_OP_BYTE = 8'h5c;
  localparam logic [4:0] STORE_ACC_LOW_OP_PRE = 5'h0c;
  localparam logic [4:0] LAR_PRE = 5'h06;
  localparam logic [4:0] SAR_PRE = 5'h0e;
  localparam logic [4:0] LOAD_INDEX_SHORT_CONST_OP_PRE = 5'h18;
  localparam logic [4:0] LOAD_INDEX_LONG_CONST_OP_PRE = 5'h1a;
  localparam logic [8:0] NORMALIZE_OP_PRE = 9'h19d;
  localparam logic [12:0] LOAD_INDEX_POINTER_OP_PRE = 13'h0ab1;
  localparam logic [6:0] LOAD_PAGE_CONST_OP_PRE = 7'h64;
  localparam logic [13:0] COMPARE_INDEX_OP_PRE = 14'h3394;
  localparam logic [2:0] MULT_CONST_OP_PRE = 3'h5;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int INDIRECT_BIT = 7;
  localparam int UPDATE_BIT = 3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NONE = 5'h00, OP_ABS = 5'h01, OP_ADD = 5'h02, OP_ADD_LONG_CONST_OP = 5'h03,
    OP_SBLK = 5'h04, OP_LALK = 5'h05, OP_AND_LONG_CONST_OP = 5'h06, OP_ORK = 5'h07,
    OP_XORK = 5'h08, OP_ADD_SHORT_CONST_OP = 5'h09, OP_SUB_SHORT_CONST_OP = 5'h0a, OP_LOAD_ACC_SHORT_CONST_OP = 5'h0b,
    OP_LACS = 5'h0c, OP_STORE_ACC_LOW_OP = 5'h0d, OP_ROL = 5'h0e, OP_ROR = 5'h0f,
    OP_SFL = 5'h10, OP_SFR = 5'h11, OP_NORMALIZE_OP = 5'h12, OP_LAR = 5'h13,
    OP_SAR = 5'h14, OP_LOAD_INDEX_SHORT_CONST_OP = 5'h15, OP_LOAD_INDEX_POINTER_OP = 5'h16, OP_LOAD_PAGE_CONST_OP = 5'h17,
    OP_LOAD_INDEX_LONG_CONST_OP = 5'h18, OP_ADD_INDEX_SHORT_CONST_OP = 5'h19, OP_COMPARE_INDEX_OP = 5'h1a, OP_MAC = 5'h1b,
    OP_MULT_ACCUMULATE_MOVE_OP = 5'h1c, OP_MULT_CONST_OP = 5'h1d, OP_ADD_PRODUCT_OP = 5'h1e, OP_PAC = 5'h1f
  } dod_op_t;

  // SUB_PRODUCT_OP and MULT_OP have no room in 5 bits; carried as separate flags
  typedef struct packed {
    logic valid;
    dod_op_t op;
    logic subProduct;
    logic multMem;
    logic twoWord;
    logic [3:0] shift;
    logic [2:0] indexSel;
    logic indirect;
    logic [6:0] memAddr;
    logic pointerLoad;
    logic [2:0] pointerNext;
    logic [15:0] constVal;
    logic [1:0] compareMode;
  } dod_ctrl_t;

  typedef enum logic [1:0] {
    ST_FIRST = 2'b00,
    ST_SECOND = 2'b01
  } dod_state_t;

endpackage

// ==== hdl/dod_match.sv ====
// Combinational pattern matcher for one 16-bit instruction word
// Assumes the word is stable while the caller samples the result
`timescale 1ns/1ns
`default_nettype none
module dod_match import dod_pkg::*; (
  input wire logic [15:0] word,
  output var dod_ctrl_t ctrl
);

  always_comb begin
    ctrl = '0;
    ctrl.op = OP_NONE;
    ctrl.shift = word[11:8];
    ctrl.indirect = word[INDIRECT_BIT];
    ctrl.memAddr = word[6:0];
    ctrl.indexSel = word[10:8];
    // Indirect field: pointer load only with update bit set
    ctrl.pointerLoad = word[INDIRECT_BIT] & word[UPDATE_BIT];
    ctrl.pointerNext = word[2:0];
    ctrl.valid = 1'b1;
    if (word == ABS_PAT) begin
      ctrl.op = OP_ABS;
      ctrl.pointerLoad = 1'b0;
    end else if (word == ROL_PAT || word == ROR_PAT) begin
      ctrl.op = word[0] ? OP_ROR : OP_ROL;
      ctrl.pointerLoad = 1'b0;
    end else if (word == SFL_PAT || word == SFR_PAT) begin
      ctrl.op = word[0] ? OP_SFR : OP_SFL;
      ctrl.pointerLoad = 1'b0;
    end else if (word == ADD_PRODUCT_OP_PAT) begin
      ctrl.op = OP_ADD_PRODUCT_OP;
      ctrl.pointerLoad = 1'b0;
    end else if (word == PAC_PAT) begin
      ctrl.op = OP_PAC;
      ctrl.pointerLoad = 1'b0;
    end else if (word == SUB_PRODUCT_OP_PAT) begin
      ctrl.subProduct = 1'b1;
      ctrl.pointerLoad = 1'b0;
    end else if (word[15:2] == COMPARE_INDEX_OP_PRE) begin
      ctrl.op = OP_COMPARE_INDEX_OP;
      ctrl.compareMode = word[1:0];
      ctrl.pointerLoad = 1'b0;
    end else if (word[15:7] == NORMALIZE_OP_PRE) begin
      ctrl.op = OP_NORMALIZE_OP;
      ctrl.indirect = 1'b1;
    end else if (word[15:3] == LOAD_INDEX_POINTER_OP_PRE) begin
      ctrl.op = OP_LOAD_INDEX_POINTER_OP;
      ctrl.pointerLoad = 1'b1;
    end else if (word[15:12] == ADD_NIB) begin
      ctrl.op = OP_ADD;
    end else if (word[15:12] == LOADSH_NIB) begin
      ctrl.op = OP_LACS;
    end else if (word[15:12] == LONG_NIB && word[7:0] != ZERO_BYTE &&
        word[7:3] == 5'h00) begin
      ctrl.twoWord = 1'b1;
      ctrl.pointerLoad = 1'b0;
      unique case (word[7:0])
        LK_ADD: ctrl.op = OP_ADD_LONG_CONST_OP;
        LK_SUB: ctrl.op = OP_SBLK;
        LK_LOAD: ctrl.op = OP_LALK;
        LK_AND: ctrl.op = OP_AND_LONG_CONST_OP;
        LK_OR: ctrl.op = OP_ORK;
        LK_XOR: ctrl.op = OP_XORK;
        default: begin
          ctrl.valid = 1'b0;
          ctrl.twoWord = 1'b0;
        end
      endcase
    end else if (word[15:11] == LOAD_INDEX_LONG_CONST_OP_PRE && word[7:0] == ZERO_BYTE) begin
      ctrl.op = OP_LOAD_INDEX_LONG_CONST_OP;
      ctrl.twoWord = 1'b1;
      ctrl.pointerLoad = 1'b0;
    end else if (word[15:8] == ADD_SHORT_CONST_OP_BYTE || word[15:8] == SUB_SHORT_CONST_OP_BYTE) begin
      ctrl.op = word[8] ? OP_SUB_SHORT_CONST_OP : OP_ADD_SHORT_CONST_OP;
      ctrl.constVal = {8'h00, word[7:0]};
      ctrl.pointerLoad = 1'b0;
    end else if (word[15:8] == LOAD_ACC_SHORT_CONST_OP_BYTE) begin
      ctrl.op = OP_LOAD_ACC_SHORT_CONST_OP;
      ctrl.constVal = {8'h00, word[7:0]};
      ctrl.pointerLoad = 1'b0;
    end else if (word[15:11] == STORE_ACC_LOW_OP_PRE) begin
      ctrl.op = OP_STORE_ACC_LOW_OP;
      ctrl.shift = {1'b0, word[10:8]};
    end else if (word[15:11] == LAR_PRE || word[15:11] == SAR_PRE) begin
      ctrl.op = (word[15:11] == SAR_PRE) ? OP_SAR : OP_LAR;
      ctrl.shift = '0;
    end else if (word[15:11] == LOAD_INDEX_SHORT_CONST_OP_PRE) begin
      ctrl.op = OP_LOAD_INDEX_SHORT_CONST_OP;
      ctrl.constVal = {8'h00, word[7:0]};
      ctrl.pointerLoad = 1'b0;
    end else if (word[15:9] == LOAD_PAGE_CONST_OP_PRE) begin
      ctrl.op = OP_LOAD_PAGE_CONST_OP;
      ctrl.constVal = {7'h00, word[8:0]};
      ctrl.pointerLoad = 1'b0;
    end else if (word[15:8] == ADD_INDEX_SHORT_CONST_OP_BYTE) begin
      ctrl.op = OP_ADD_INDEX_SHORT_CONST_OP;
      ctrl.constVal = {8'h00, word[7:0]};
      ctrl.pointerLoad = 1'b0;
    end else if (word[15:8] == MAC_BYTE || word[15:8] == MULT_ACCUMULATE_MOVE_OP_BYTE) begin
      ctrl.op = word[8] ? OP_MAC : OP_MULT_ACCUMULATE_MOVE_OP;
      ctrl.twoWord = 1'b1;
    end else if (word[15:13] == MULT_CONST_OP_PRE) begin
      ctrl.op = OP_MULT_CONST_OP;
      ctrl.constVal = {{3{word[12]}}, word[12:0]};
      ctrl.pointerLoad = 1'b0;
    end else if (word[15:8] == MPY_BYTE) begin
      ctrl.multMem = 1'b1;
    end else begin
      ctrl = '0;
      ctrl.op = OP_NONE;
    end
    if (!ctrl.valid) begin
      ctrl = '0;
      ctrl.op = OP_NONE;
    end
  end

endmodule // dod_match
`default_nettype wire

// ==== hdl/dod_decoder.sv ====
// Opcode decoder top: accumulator, index-register and multiply groups
// Assumes fetch presents one word per cycle with wordValid
`timescale 1ns/1ns
`default_nettype none
module dod_decoder import dod_pkg::*; (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic wordValid,
  input wire logic [15:0] word,
  output logic ctrlValid,
  output var dod_ctrl_t ctrl
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    dod_state_t phase;
    dod_ctrl_t held;
    logic outValid;
    dod_ctrl_t out;
  } dod_regs_t;

  dod_regs_t r;
  dod_regs_t next_r;
  dod_ctrl_t matched;

  dod_match matcher (
    .word(word),
    .ctrl(matched)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.outValid = 1'b0;
    if (wordValid) begin
      unique case (r.phase)
        ST_FIRST: begin
          if (matched.twoWord) begin
            next_r.held = matched;
            next_r.phase = ST_SECOND;
          end else begin
            next_r.out = matched;
            next_r.outValid = matched.valid;
          end
        end
        ST_SECOND: begin
          next_r.out = r.held;
          if (r.held.op != OP_MAC && r.held.op != OP_MULT_ACCUMULATE_MOVE_OP) begin
            next_r.out.constVal = word;
          end else begin
            next_r.out.constVal = word;
          end
          next_r.outValid = 1'b1;
          next_r.phase = ST_FIRST;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign ctrlValid = r.outValid;
  assign ctrl = r.out;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  abs_decode_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (wordValid && r.phase == ST_FIRST && word == ABS_PAT) |=>
    ctrlValid && ctrl.op == OP_ABS)
    else $error("abs not decoded");
  add_shift_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (wordValid && r.phase == ST_FIRST && word[15:12] == 4'h0) |=>
    ctrl.op == OP_ADD && ctrl.shift == $past(word[11:8]))
    else $error("add shift wrong");
  long_two_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (wordValid && r.phase == ST_FIRST && word == 16'hd302) ##1
    wordValid |=> ctrlValid && ctrl.op == OP_ADD_LONG_CONST_OP &&
    ctrl.shift == 4'h3 && ctrl.constVal == $past(word))
    else $error("long add wrong");
  long_sel_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (wordValid && r.phase == ST_FIRST && word[15:12] == LONG_NIB &&
    word[7:0] == LK_XOR) |=>
    !ctrlValid ##0 r.held.op == OP_XORK)
    else $error("xor select wrong");
  sub_short_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (wordValid && r.phase == ST_FIRST && word[15:8] == SUB_SHORT_CONST_OP_BYTE) |=>
    ctrl.op == OP_SUB_SHORT_CONST_OP && ctrl.constVal[7:0] == $past(word[7:0]))
    else $error("short sub wrong");
  store_acc_low_op_shift_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (wordValid && r.phase == ST_FIRST && word[15:11] == STORE_ACC_LOW_OP_PRE) |=>
    ctrl.op == OP_STORE_ACC_LOW_OP && ctrl.shift == {1'b0, $past(word[10:8])})
    else $error("store shift wrong");
  mult_const_op_sign_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (wordValid && r.phase == ST_FIRST && word == 16'hb000) |=>
    ctrl.op == OP_MULT_CONST_OP && ctrl.constVal == 16'hf000)
    else $error("mult_const_op sign wrong");
  ptr_update_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (wordValid && r.phase == ST_FIRST && word == 16'h08ab) |=>
    ctrl.pointerLoad && ctrl.pointerNext == 3'h3)
    else $error("pointer update wrong");
  unknown_none_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    (wordValid && r.phase == ST_FIRST && word == 16'hfe00) |=>
    !ctrlValid)
    else $error("unknown word decoded");

  two_word_c: cover property (@(posedge sys_clk) disable iff (!resetn)
    r.phase == ST_SECOND ##1 ctrlValid);
  mac_c: cover property (@(posedge sys_clk) disable iff (!resetn)
    ctrlValid && ctrl.op == OP_MAC);
  compare_index_op_c: cover property (@(posedge sys_clk) disable iff (!resetn)
    ctrlValid && ctrl.op == OP_COMPARE_INDEX_OP);

endmodule // dod_decoder
`default_nettype wire

// ==== sim/dod_fetch_model.sv ====
// Fetch-side model: hands queued words to the decoder one per cycle
// Assumes the bench pushes words in legal order and drives stall
`timescale 1ns/1ns
`default_nettype none
module dod_fetch_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic stall,
  output logic wordValid,
  output logic [15:0] word
);
  logic [15:0] pend [$];

  task automatic push(input logic [15:0] w);
    pend.push_back(w);
  endtask

  // ----------------------------------------------------------------
  // Word delivery, idle bus inverts its previous value each cycle
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wordValid <= 1'b0;
      word <= 16'h0000;
    end else if (!stall && pend.size() > 0) begin
      wordValid <= 1'b1;
      word <= pend.pop_front();
    end else begin
      wordValid <= 1'b0;
      word <= ~word;
    end
  end
endmodule // dod_fetch_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the opcode decoder
// Assumes the fetch model in sim/ and the decoder top in hdl/
`timescale 1ns/1ns
`default_nettype none
module tb_top import dod_pkg::*; ;
  logic sys_clk;
  logic resetn;
  logic stall;
  logic wordValid;
  logic [15:0] word;
  logic ctrlValid;
  dod_ctrl_t ctrl;
  int n_mismatch = 0;
  int n_checks = 0;
  integer seed = 45681;
  logic [15:0] expW [$];
  logic [15:0] expK [$];
  logic [15:0] corner [$] = '{16'hce1b, 16'h08ab, 16'h0f05, 16'hd302,
    16'hd303, 16'hd001, 16'hd404, 16'hd505, 16'hd606, 16'hcc80, 16'hcdff,
    16'hcaa5, 16'h2c9f, 16'h6588, 16'hce34, 16'hce35, 16'hce18, 16'hce19,
    16'hce8b, 16'h3512, 16'h7598, 16'hc7ff, 16'h558d, 16'hc9ff, 16'hd500,
    16'h7e11, 16'hce53, 16'h5d8a, 16'h5c00, 16'hb000, 16'hafff, 16'hce15,
    16'hce14, 16'hce16, 16'h38ff, 16'hce00, 16'hfe00, 16'hce1a};

  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  dod_fetch_model fetch (.sys_clk(sys_clk), .resetn(resetn),
    .stall(stall), .wordValid(wordValid), .word(word));
  dod_decoder uut (.sys_clk(sys_clk), .resetn(resetn),
    .wordValid(wordValid), .word(word), .ctrlValid(ctrlValid),
    .ctrl(ctrl));

  // ----------------------------------------------------------------
  // Compare, verdict and reference decode
  // ----------------------------------------------------------------
  task automatic cmp(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_checks++;
    if (e !== g) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  function automatic dod_op_t ref_op(input logic [15:0] w);
    casez (w)
      16'hce1b: return OP_ABS;
      16'hce34: return OP_ROL;
      16'hce35: return OP_ROR;
      16'hce18: return OP_SFL;
      16'hce19: return OP_SFR;
      16'hce15: return OP_ADD_PRODUCT_OP;
      16'hce14: return OP_PAC;
      16'b1100_1110_1???_????: return OP_NORMALIZE_OP;
      16'b1100_1110_0101_00??: return OP_COMPARE_INDEX_OP;
      16'h0???: return OP_ADD;
      16'h2???: return OP_LACS;
      16'hd?02: return OP_ADD_LONG_CONST_OP;
      16'hd?03: return OP_SBLK;
      16'hd?01: return OP_LALK;
      16'hd?04: return OP_AND_LONG_CONST_OP;
      16'hd?05: return OP_ORK;
      16'hd?06: return OP_XORK;
      16'b1101_0???_00000000: return OP_LOAD_INDEX_LONG_CONST_OP;
      16'hcc??: return OP_ADD_SHORT_CONST_OP;
      16'hcd??: return OP_SUB_SHORT_CONST_OP;
      16'hca??: return OP_LOAD_ACC_SHORT_CONST_OP;
      16'h7e??: return OP_ADD_INDEX_SHORT_CONST_OP;
      16'b0110_0???_????_????: return OP_STORE_ACC_LOW_OP;
      16'b0011_0???_????_????: return OP_LAR;
      16'b0111_0???_????_????: return OP_SAR;
      16'b1100_0???_????_????: return OP_LOAD_INDEX_SHORT_CONST_OP;
      16'b0101_0101_1000_1???: return OP_LOAD_INDEX_POINTER_OP;
      16'b1100_100?_????_????: return OP_LOAD_PAGE_CONST_OP;
      16'h5d??: return OP_MAC;
      16'h5c??: return OP_MULT_ACCUMULATE_MOVE_OP;
      16'b101?_????_????_????: return OP_MULT_CONST_OP;
      default: return OP_NONE;
    endcase
  endfunction

  function automatic logic two_word(input dod_op_t o);
    return o inside {OP_ADD_LONG_CONST_OP, OP_SBLK, OP_LALK, OP_AND_LONG_CONST_OP, OP_ORK, OP_XORK,
      OP_LOAD_INDEX_LONG_CONST_OP, OP_MAC, OP_MULT_ACCUMULATE_MOVE_OP};
  endfunction

  task automatic check_ctrl(input logic [15:0] w, input logic [15:0] k,
                            input dod_ctrl_t c);
    dod_op_t o;
    o = ref_op(w);
    cmp("op", o, c.op);
    cmp("subProduct", w == 16'hce16, c.subProduct);
    cmp("multMem", w[15:8] == 8'h38, c.multMem);
    cmp("twoWord", two_word(o), c.twoWord);
    case (o)
      OP_ADD, OP_LACS: begin
        cmp("shift", w[11:8], c.shift);
        cmp("indirect", w[7], c.indirect);
        if (w[7]) cmp("ptrLoad", w[3], c.pointerLoad);
        if (w[7] && w[3]) cmp("ptrNext", w[2:0], c.pointerNext);
        if (!w[7]) cmp("memAddr", w[6:0], c.memAddr);
      end
      OP_ADD_LONG_CONST_OP, OP_SBLK, OP_LALK, OP_AND_LONG_CONST_OP, OP_ORK, OP_XORK: begin
        cmp("shift", w[11:8], c.shift);
        cmp("const", k, c.constVal);
      end
      OP_ADD_SHORT_CONST_OP, OP_SUB_SHORT_CONST_OP, OP_LOAD_ACC_SHORT_CONST_OP, OP_ADD_INDEX_SHORT_CONST_OP:
        cmp("const", w[7:0], c.constVal[7:0]);
      OP_STORE_ACC_LOW_OP: cmp("shift", w[10:8], c.shift);
      OP_LAR, OP_SAR: cmp("indexSel", w[10:8], c.indexSel);
      OP_LOAD_INDEX_SHORT_CONST_OP: begin
        cmp("indexSel", w[10:8], c.indexSel);
        cmp("const", w[7:0], c.constVal[7:0]);
      end
      OP_LOAD_INDEX_LONG_CONST_OP: begin
        cmp("indexSel", w[10:8], c.indexSel);
        cmp("const", k, c.constVal);
      end
      OP_LOAD_INDEX_POINTER_OP: cmp("ptrNext", w[2:0], c.pointerNext);
      OP_LOAD_PAGE_CONST_OP: cmp("page", w[8:0], c.constVal[8:0]);
      OP_COMPARE_INDEX_OP: cmp("mode", w[1:0], c.compareMode);
      OP_MAC, OP_MULT_ACCUMULATE_MOVE_OP: cmp("const", k, c.constVal);
      OP_MULT_CONST_OP: cmp("const", {{3{w[12]}}, w[12:0]}, c.constVal);
      OP_NORMALIZE_OP: cmp("ptrLoad", w[3], c.pointerLoad);
      default: ;
    endcase
  endtask

  // ----------------------------------------------------------------
  // Stimulus and monitor
  // ----------------------------------------------------------------
  task automatic issue(input logic [15:0] w);
    logic [15:0] k;
    k = 16'($random(seed));
    fetch.push(w);
    if (two_word(ref_op(w))) fetch.push(k);
    if (ref_op(w) != OP_NONE || w == 16'hce16 || w[15:8] == 8'h38) begin
      expW.push_back(w);
      expK.push_back(k);
    end
  endtask

  task automatic drain;
    int i;
    for (i = 0; i < 3000 && (expW.size() > 0 || fetch.pend.size() > 0);
         i++) @(posedge sys_clk);
    if (i == 3000) cmp("timeout", 16'h0000, 16'h0001);
    repeat (4) @(posedge sys_clk);
    cmp("pending", 16'h0000, expW.size());
  endtask

  always @(posedge sys_clk) begin
    if (resetn === 1'b1 && ctrlValid !== 1'b0) begin
      if (expW.size() == 0) cmp("spurious", 16'h0000, 16'h0001);
      else check_ctrl(expW.pop_front(), expK.pop_front(), ctrl);
    end
  end

  initial begin
    resetn = 1'b0;
    stall = 1'b0;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    foreach (corner[i]) issue(corner[i]);
    drain();
    issue(16'hd302);
    @(posedge sys_clk);
    resetn <= 1'b0;
    fetch.pend.delete();
    expW.delete();
    expK.delete();
    repeat (2) @(posedge sys_clk);
    cmp("rstValid", 16'h0000, ctrlValid);
    cmp("rstOp", 16'h0000, ctrl.op);
    resetn <= 1'b1;
    for (int i = 0; i < 400; i++) begin
      @(posedge sys_clk);
      stall <= ($random(seed) & 3) == 0;
      issue(16'($random(seed)));
    end
    stall <= 1'b0;
    drain();
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
